//--- src/hsa_consts.vh
`ifndef HSA_CONSTS_VH
`define HSA_CONSTS_VH
// ****************************************
// register indices within a line number
// ****************************************
`define HSA_IDX_ID 3'h0
`define HSA_IDX_LCR 3'h2
`define HSA_IDX_DCR 3'h3
`define HSA_IDX_STAT 3'h5
`define HSA_IDX_DATA 3'h7
// ****************************************
// line control and dce control bits
// ****************************************
`define HSA_LC_RXEN 0
`define HSA_LC_TXEN 1
`define HSA_LC_TEST 2
`define HSA_LC_CSEL 3
`define HSA_LC_DTR 4
`define HSA_LC_RTS 5
`define HSA_LC_RSEL 6
`define HSA_LC_NS 7
`define HSA_DC_LL 0
`define HSA_DC_RL 1
// ****************************************
// identifiers (values arbitrary)
// ****************************************
`define HSA_ID_DATA 16'h5A00
`define HSA_ID_NULL 16'h0400
`define HSA_ID_FAULT 16'h8000
// ****************************************
// data word fields
// ****************************************
`define HSA_TX_TEOM 8
`define HSA_TX_TSOM 9
`define HSA_RW_EOM 8
`define HSA_RW_ABORT 9
`define HSA_RW_RO 10
`define HSA_RW_FE 11
`define HSA_RW_IDLE 12
// ****************************************
// framing
// ****************************************
`define HSA_FLAG 8'h7E
`define HSA_ABORT 8'hFF
`define HSA_ONES_STUFF 4'h5
`define HSA_ONES_FLAG 4'h6
`define HSA_ONES_IDLE 4'hE
`define HSA_ONES_MAX 4'hF
// ****************************************
// synchroniser bit positions (per line add g)
// ****************************************
`define HSA_S_RXD 0
`define HSA_S_TXC 2
`define HSA_S_RXC 4
`define HSA_S_CTS 6
`define HSA_S_DSR 8
`define HSA_S_DCD 10
`define HSA_S_RI 12
`define HSA_S_TM 14
`define HSA_S_INT 16
`define HSA_S_FAULT 17
`define HSA_S_W 18
`endif

//--- src/hsa_rx.v
`include "hsa_consts.vh"
module hsa_rx (
  input wire clk,
  input wire rst_n,
  input wire en,
  input wire strobe,
  input wire bit_in,
  input wire take,
  output reg [12:0] hold_reg,
  output reg hold_v_reg
);
  reg [3:0] ones_reg;
  reg sync_reg;
  reg drop_reg;
  reg idle_done_reg;
  reg [7:0] byte_reg;
  reg [2:0] cnt_reg;
  reg [7:0] pend_reg;
  reg pend_v_reg;
  reg [3:0] ones_next;
  reg is_flag;
  reg is_stuff;
  reg is_abort;
  reg is_idle;
  reg assemble;
  reg push;
  reg [12:0] push_w;
  wire [7:0] new_byte = {bit_in, byte_reg[7:1]};

  always @*
  begin
    ones_next = bit_in ? ((ones_reg == `HSA_ONES_MAX) ? ones_reg : ones_reg + 4'h1) : 4'h0;
    is_flag = strobe & ~bit_in & (ones_reg == `HSA_ONES_FLAG);
    is_stuff = strobe & ~bit_in & (ones_reg == `HSA_ONES_STUFF);
    is_abort = strobe & bit_in & (ones_reg == `HSA_ONES_FLAG);
    is_idle = strobe & bit_in & (ones_reg == `HSA_ONES_IDLE);
    assemble = strobe & sync_reg & ~drop_reg & ~is_flag & ~is_stuff & ~is_abort;
    push = 1'b0;
    push_w = 13'h0000;
    // the byte before a flag is the last one; misaligned flag marks a frame error
    if (is_flag & sync_reg & pend_v_reg & ~drop_reg)
    begin
      push = 1'b1;
      push_w = {2'b00, 1'b0, 1'b0, 1'b1, pend_reg};
      push_w[`HSA_RW_FE] = (cnt_reg != 3'h7);
    end
    else if (assemble & (cnt_reg == 3'h7) & pend_v_reg)
    begin
      push = 1'b1;
      push_w = {5'h00, pend_reg};
    end
    else if (is_abort & sync_reg & ~drop_reg)
    begin
      push = 1'b1;
      push_w[`HSA_RW_ABORT] = 1'b1;
      push_w[`HSA_RW_EOM] = 1'b1;
    end
    else if (is_idle & ~idle_done_reg)
    begin
      push = 1'b1;
      push_w[`HSA_RW_IDLE] = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n || !en)
    begin
      ones_reg <= 4'h0;
      sync_reg <= 1'b0;
      drop_reg <= 1'b0;
      idle_done_reg <= 1'b0;
      byte_reg <= 8'h00;
      cnt_reg <= 3'h0;
      pend_reg <= 8'h00;
      pend_v_reg <= 1'b0;
      hold_reg <= 13'h0000;
      hold_v_reg <= 1'b0;
    end
    else
    begin
      if (strobe)
        ones_reg <= ones_next;
      if (strobe & ~bit_in)
        idle_done_reg <= 1'b0;
      if (is_idle)
        idle_done_reg <= 1'b1;
      if (is_flag)
      begin
        sync_reg <= 1'b1;
        drop_reg <= 1'b0;
        cnt_reg <= 3'h0;
        pend_v_reg <= 1'b0;
      end
      else if (is_abort)
      begin
        sync_reg <= 1'b0;
        pend_v_reg <= 1'b0;
      end
      else if (assemble)
      begin
        byte_reg <= new_byte;
        cnt_reg <= cnt_reg + 3'h1;
        if (cnt_reg == 3'h7)
        begin
          pend_reg <= new_byte;
          pend_v_reg <= 1'b1;
        end
      end
      // word kept until collected; a push onto a full holder marks overrun
      if (push & (~hold_v_reg | take))
      begin
        hold_reg <= push_w;
        hold_v_reg <= 1'b1;
      end
      else if (push)
      begin
        hold_reg[`HSA_RW_RO] <= 1'b1;
        hold_reg[`HSA_RW_EOM] <= 1'b1;
        if (!is_flag)
          drop_reg <= 1'b1;
        pend_v_reg <= 1'b0;
      end
      else if (take)
        hold_v_reg <= 1'b0;
    end
  end
endmodule

//--- src/hsa_tx.v
`include "hsa_consts.vh"
module hsa_tx (
  input wire clk,
  input wire rst_n,
  input wire en,
  input wire strobe,
  input wire load,
  input wire [7:0] ldata,
  input wire teom,
  input wire tsom,
  output reg bit_reg,
  output wire rdy,
  output reg und_reg
);
  reg [7:0] buf_reg;
  reg buf_eom_reg;
  reg buf_v_reg;
  reg [7:0] sh_reg;
  reg [2:0] cnt_reg;
  reg [2:0] ones_reg;
  reg raw_reg;
  reg in_data_reg;
  reg last_reg;

  // ready stays up during underrun so the program keeps feeding
  assign rdy = en & ~buf_v_reg;

  always @(posedge clk)
  begin
    if (!rst_n || !en)
    begin
      buf_reg <= 8'h00;
      buf_eom_reg <= 1'b0;
      buf_v_reg <= 1'b0;
      sh_reg <= `HSA_FLAG;
      cnt_reg <= 3'h0;
      ones_reg <= 3'h0;
      raw_reg <= 1'b1;
      in_data_reg <= 1'b0;
      last_reg <= 1'b0;
      und_reg <= 1'b0;
      bit_reg <= 1'b1;
    end
    else
    begin
      if (load)
      begin
        if (tsom)
          und_reg <= 1'b0;
        if (!und_reg || tsom)
        begin
          buf_reg <= ldata;
          buf_eom_reg <= teom;
          buf_v_reg <= 1'b1;
        end
      end
      if (strobe)
      begin
        // stuff after five data ones even when a flag or abort comes next
        if ({1'b0, ones_reg} == `HSA_ONES_STUFF)
        begin
          bit_reg <= 1'b0;
          ones_reg <= 3'h0;
        end
        else
        begin
          bit_reg <= sh_reg[0];
          sh_reg <= {1'b0, sh_reg[7:1]};
          ones_reg <= (sh_reg[0] && !raw_reg) ? ones_reg + 3'h1 : 3'h0;
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7)
          begin
            if (in_data_reg && last_reg)
            begin
              sh_reg <= `HSA_FLAG;
              raw_reg <= 1'b1;
              in_data_reg <= 1'b0;
            end
            else if (buf_v_reg && !und_reg)
            begin
              sh_reg <= buf_reg;
              raw_reg <= 1'b0;
              in_data_reg <= 1'b1;
              last_reg <= buf_eom_reg;
              buf_v_reg <= 1'b0;
            end
            else if (in_data_reg)
            begin
              // starved mid-frame: abort, then flags until a new start
              sh_reg <= `HSA_ABORT;
              raw_reg <= 1'b1;
              in_data_reg <= 1'b0;
              und_reg <= 1'b1;
            end
            else
            begin
              sh_reg <= `HSA_FLAG;
              raw_reg <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule

//--- src/hsa_top.v
// Our own choices: the placing of the registers and the plain strobed port.
`include "hsa_consts.vh"
// How it works
// - each channel raises its own service request, only when it needs service
// - receive ready stays true while data or status awaits collection
// - receiver raises no requests while its receive enable bit is clear
// - transmitter raises no requests while its transmit enable bit is clear
// - one high priority request output; receive served before transmit
// - receive on lines 8n+4, 8n+6; transmit on 8n+5, 8n+7
// - lowest line numbers of the group are null, carry no data
// - test bit loops transmit data internally into the receiver
// - in test mode a steady one is sent toward the modem
// - in test mode bit clock follows clock source bit
// - loop bits in dce control drive loopback request circuits
// - data lines give fixed identifier; fault forces its top bit
// - null lines give a different fixed identifier
// - identifier register returns identifier high byte
// - modem side drives and receives the full circuit set
// - each channel runs up to 19,200 bit/s, all at once
// - overrun, underrun and frame errors reported as status
// - transmit requests on each false to true change of ready
// - clock source bit picks modem clock or controller clock
module hsa_top (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [1:0] board_loc,
  input wire adapter_fault,
  input wire int_clk,
  input wire [1:0] dce_rxd,
  input wire [1:0] dce_cts,
  input wire [1:0] dce_dsr,
  input wire [1:0] dce_dcd,
  input wire [1:0] dce_txc,
  input wire [1:0] dce_rxc,
  input wire [1:0] dce_ri,
  input wire [1:0] dce_tm,
  output wire [1:0] dce_txd,
  output wire [1:0] dce_rts,
  output wire [1:0] dce_dtr,
  output wire [1:0] dce_ns,
  output wire [1:0] local_loop_request,
  output wire [1:0] remote_loop_request,
  output wire [1:0] dce_rsel,
  output wire [3:0] svc_req_ch,
  output reg service_request,
  output reg [4:0] svc_line
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [`HSA_S_W-1:0] async_in;
  reg [`HSA_S_W-1:0] s1_reg;
  reg [`HSA_S_W-1:0] s2_reg;
  reg [`HSA_S_W-1:0] s3_reg;
  reg [1:0] loc_s1_reg;
  reg [1:0] loc_reg;

  assign async_in = {adapter_fault, int_clk, dce_tm, dce_ri, dce_dcd, dce_dsr,
                     dce_cts, dce_rxc, dce_txc, dce_rxd};

  // clocks sampled at 125 MHz; far above 19,200 bit/s per channel
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= {`HSA_S_W{1'b0}};
      s2_reg <= {`HSA_S_W{1'b0}};
      s3_reg <= {`HSA_S_W{1'b0}};
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // static strap, but still a pin: two stages like the others
  always @(posedge clk)
  begin
    if (!rst_n)
      {loc_reg, loc_s1_reg} <= 4'h0;
    else
      {loc_reg, loc_s1_reg} <= {loc_s1_reg, board_loc};
  end

  // ****************************************
  // address decode
  // ****************************************
  wire [2:0] idx = reg_addr[2:0];
  wire [2:0] ln_off = reg_addr[5:3];
  wire own = (reg_addr[7:6] == loc_reg);
  wire data_ln = own & ln_off[2];
  wire null_ln = own & ~ln_off[2];
  wire pair = ln_off[1];
  wire is_tx = ln_off[0];

  // ****************************************
  // per line logic
  // ****************************************
  wire [15:0] lcr_w;
  wire [3:0] dcr_w;
  wire [15:0] stat_w;
  wire [25:0] rxw_w;
  wire [3:0] req_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gl
      reg [7:0] lcr_reg;
      reg [1:0] dcr_reg;
      reg req_rx_reg;
      reg req_tx_reg;
      reg rx_rdy_p_reg;
      reg tx_rdy_p_reg;
      reg txd_reg;
      reg rts_reg;
      reg dtr_reg;
      reg ns_reg;
      reg ll_reg;
      reg rl_reg;
      reg rsel_reg;
      wire hit = data_ln & (pair == g);
      wire rx_en = lcr_reg[`HSA_LC_RXEN];
      wire tx_en = lcr_reg[`HSA_LC_TXEN];
      wire test = lcr_reg[`HSA_LC_TEST];
      wire csel = lcr_reg[`HSA_LC_CSEL];
      wire take = reg_rd & hit & ~is_tx & (idx == `HSA_IDX_DATA);
      wire load = reg_wr & hit & is_tx & (idx == `HSA_IDX_DATA);
      // clock source: modem clocks or controller clock
      wire tclk_c = csel ? s2_reg[`HSA_S_INT] : s2_reg[`HSA_S_TXC + g];
      wire tclk_p = csel ? s3_reg[`HSA_S_INT] : s3_reg[`HSA_S_TXC + g];
      wire rclk_e_c = csel ? s2_reg[`HSA_S_INT] : s2_reg[`HSA_S_RXC + g];
      wire rclk_e_p = csel ? s3_reg[`HSA_S_INT] : s3_reg[`HSA_S_RXC + g];
      wire rclk_c = test ? tclk_c : rclk_e_c;
      wire rclk_p = test ? tclk_p : rclk_e_p;
      // transmit changes on falling edge, receive samples on rising
      wire tx_stb = tclk_p & ~tclk_c;
      wire rx_stb = ~rclk_p & rclk_c;
      wire tx_bit;
      wire tx_rdy;
      wire tx_und;
      wire [12:0] rx_word;
      wire rx_rdy;
      wire rx_in = test ? tx_bit : s2_reg[`HSA_S_RXD + g];

      hsa_tx u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .en(tx_en),
        .strobe(tx_stb),
        .load(load),
        .ldata(reg_wdata[7:0]),
        .teom(reg_wdata[`HSA_TX_TEOM]),
        .tsom(reg_wdata[`HSA_TX_TSOM]),
        .bit_reg(tx_bit),
        .rdy(tx_rdy),
        .und_reg(tx_und)
      );

      hsa_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .en(rx_en),
        .strobe(rx_stb),
        .bit_in(rx_in),
        .take(take),
        .hold_reg(rx_word),
        .hold_v_reg(rx_rdy)
      );

      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          lcr_reg <= 8'h00;
          dcr_reg <= 2'h0;
        end
        else if (reg_wr & hit)
        begin
          // one control set per line, reached from either channel number
          if (idx == `HSA_IDX_LCR)
            lcr_reg <= reg_wdata[7:0];
          if (idx == `HSA_IDX_DCR)
            dcr_reg <= reg_wdata[1:0];
        end
      end

      // requests: set on a new need, dropped by service or disable
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          req_rx_reg <= 1'b0;
          req_tx_reg <= 1'b0;
          rx_rdy_p_reg <= 1'b0;
          tx_rdy_p_reg <= 1'b0;
        end
        else
        begin
          rx_rdy_p_reg <= rx_rdy;
          tx_rdy_p_reg <= tx_rdy;
          if (!rx_en)
            req_rx_reg <= 1'b0;
          else if (rx_rdy & ~rx_rdy_p_reg)
            req_rx_reg <= 1'b1;
          else if (take)
            req_rx_reg <= 1'b0;
          if (!tx_en)
            req_tx_reg <= 1'b0;
          else if (tx_rdy & ~tx_rdy_p_reg)
            req_tx_reg <= 1'b1;
          else if (load)
            req_tx_reg <= 1'b0;
        end
      end

      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          txd_reg <= 1'b1;
          rts_reg <= 1'b0;
          dtr_reg <= 1'b0;
          ns_reg <= 1'b0;
          ll_reg <= 1'b0;
          rl_reg <= 1'b0;
          rsel_reg <= 1'b0;
        end
        else
        begin
          txd_reg <= test | tx_bit;
          rts_reg <= lcr_reg[`HSA_LC_RTS];
          dtr_reg <= lcr_reg[`HSA_LC_DTR];
          ns_reg <= lcr_reg[`HSA_LC_NS];
          rsel_reg <= lcr_reg[`HSA_LC_RSEL];
          ll_reg <= dcr_reg[`HSA_DC_LL];
          rl_reg <= dcr_reg[`HSA_DC_RL];
        end
      end

      assign dce_txd[g] = txd_reg;
      assign dce_rts[g] = rts_reg;
      assign dce_dtr[g] = dtr_reg;
      assign dce_ns[g] = ns_reg;
      assign dce_rsel[g] = rsel_reg;
      assign local_loop_request[g] = ll_reg;
      assign remote_loop_request[g] = rl_reg;
      assign lcr_w[g*8 +: 8] = lcr_reg;
      assign dcr_w[g*2 +: 2] = dcr_reg;
      assign stat_w[g*8 +: 8] = {s2_reg[`HSA_S_TM + g], s2_reg[`HSA_S_RI + g],
                                 s2_reg[`HSA_S_DCD + g], s2_reg[`HSA_S_DSR + g],
                                 s2_reg[`HSA_S_CTS + g], tx_und, tx_rdy, rx_rdy};
      assign rxw_w[g*13 +: 13] = rx_word;
      assign req_w[g*2] = req_rx_reg;
      assign req_w[g*2+1] = req_tx_reg;
    end
  endgenerate

  assign svc_req_ch = req_w;

  // ****************************************
  // request priority
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      service_request <= 1'b0;
      svc_line <= 5'h00;
    end
    else
    begin
      service_request <= |req_w;
      // receive first, then transmit; line = 8n + 4 + 2*pair + dir
      if (req_w[0])
        svc_line <= {loc_reg, 3'h4};
      else if (req_w[2])
        svc_line <= {loc_reg, 3'h6};
      else if (req_w[1])
        svc_line <= {loc_reg, 3'h5};
      else if (req_w[3])
        svc_line <= {loc_reg, 3'h7};
      else
        svc_line <= 5'h00;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  wire [15:0] id_full = null_ln ? `HSA_ID_NULL :
                        (s2_reg[`HSA_S_FAULT] ? (`HSA_ID_DATA | `HSA_ID_FAULT)
                                              : `HSA_ID_DATA);
  reg [15:0] rd_next;

  always @*
  begin
    rd_next = 16'h0000;
    if (own && idx == `HSA_IDX_ID)
      rd_next = {8'h00, id_full[15:8]};
    else if (data_ln)
    begin
      case (idx)
        `HSA_IDX_LCR: rd_next = {8'h00, lcr_w[pair*8 +: 8]};
        `HSA_IDX_DCR: rd_next = {14'h0000, dcr_w[pair*2 +: 2]};
        `HSA_IDX_STAT: rd_next = {8'h00, stat_w[pair*8 +: 8]};
        `HSA_IDX_DATA: rd_next = is_tx ? 16'h0000 : {3'h0, rxw_w[pair*13 +: 13]};
        default: rd_next = 16'h0000;
      endcase
    end
  end

  // answer stands only in the cycle after the read strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 16'h0000;
  end
endmodule

//--- dv/hsa_assertions.sv
`include "hsa_consts.vh"
module hsa_checker (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [1:0] board_loc,
  input wire adapter_fault,
  input wire [1:0] dce_txd,
  input wire [1:0] dce_rts,
  input wire [1:0] dce_dtr,
  input wire [1:0] local_loop_request,
  input wire [1:0] remote_loop_request,
  input wire [3:0] svc_req_ch,
  input wire service_request,
  input wire [4:0] svc_line
);
  localparam logic [15:0] IDD = `HSA_ID_DATA;
  localparam logic [15:0] IDN = `HSA_ID_NULL;
  localparam logic [15:0] IDF = `HSA_ID_FAULT;
  logic [1:0] rxen, txen, test, dtr, rts, ll, rl;
  wire own = (reg_addr[7:6] == board_loc) && reg_addr[5];
  // ****************************************
  // shadow of control bits seen on the bus
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
      {rxen, txen, test, dtr, rts, ll, rl} <= 14'h0000;
    else if (reg_wr && own && reg_addr[2:0] == `HSA_IDX_LCR)
    begin
      rxen[reg_addr[4]] <= reg_wdata[`HSA_LC_RXEN];
      txen[reg_addr[4]] <= reg_wdata[`HSA_LC_TXEN];
      test[reg_addr[4]] <= reg_wdata[`HSA_LC_TEST];
      dtr[reg_addr[4]] <= reg_wdata[`HSA_LC_DTR];
      rts[reg_addr[4]] <= reg_wdata[`HSA_LC_RTS];
    end
    else if (reg_wr && own && reg_addr[2:0] == `HSA_IDX_DCR)
    begin
      ll[reg_addr[4]] <= reg_wdata[`HSA_DC_LL];
      rl[reg_addr[4]] <= reg_wdata[`HSA_DC_RL];
    end
  end
  // receive lines first, then transmit
  function automatic logic [4:0] exp_line(input logic [3:0] c, input logic [1:0] l);
    if (c[0]) return {l, 3'h4};
    if (c[2]) return {l, 3'h6};
    if (c[1]) return {l, 3'h5};
    if (c[3]) return {l, 3'h7};
    return 5'h00;
  endfunction
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_svc_or: assert property (service_request == |$past(svc_req_ch))
    else $error("service request is not the or of channel requests");
  a_line_prio: assert property (svc_line == exp_line($past(svc_req_ch), board_loc))
    else $error("wrong line number presented");
  a_rx_gate: assert property (((svc_req_ch[0] & ~$past(rxen[0])) | (svc_req_ch[2] & ~$past(rxen[1]))) == 1'b0)
    else $error("receive request while receive disabled");
  a_tx_gate: assert property (((svc_req_ch[1] & ~$past(txen[0])) | (svc_req_ch[3] & ~$past(txen[1]))) == 1'b0)
    else $error("transmit request while transmit disabled");
  a_tx_start: assert property ($rose(txen[0]) |-> ##[1:4] svc_req_ch[1])
    else $error("no transmit request after enable");
  a_test_mark: assert property (((~dce_txd) & $past(test)) == 2'b00)
    else $error("transmitted data not held at one in test mode");
  a_dce_ctl: assert property ($stable({ll, rl, dtr, rts}) |->
    {local_loop_request, remote_loop_request, dce_dtr, dce_rts} == {ll, rl, dtr, rts})
    else $error("modem control outputs differ from control bits");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  a_id_read: assert property (reg_rd && reg_addr[7:6] == board_loc && reg_addr[2:0] == `HSA_IDX_ID |=>
    reg_rdata == {8'h00, $past(reg_addr[5]) ? ($past(adapter_fault, 3) ? (IDD[15:8] | IDF[15:8]) :
    IDD[15:8]) : IDN[15:8]})
    else $error("wrong identifier byte");
  c_rx_served: cover property (service_request && svc_line[2:0] == 3'h4);
  c_tx_served: cover property (service_request && svc_line[2:0] == 3'h7);
  c_loop: cover property (|local_loop_request);
endmodule
bind hsa_top hsa_checker chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .board_loc, .adapter_fault, .dce_txd, .dce_rts, .dce_dtr, .local_loop_request,
  .remote_loop_request, .svc_req_ch, .service_request, .svc_line);

//--- dv/hsa_dce_model.sv
module hsa_dce_model (
  input wire run,
  input wire [1:0] dce_txd,
  input wire [1:0] dce_rts,
  input wire [1:0] dce_dtr,
  input wire [1:0] local_loop_request,
  input wire [1:0] remote_loop_request,
  output wire [1:0] dce_rxd,
  output wire [1:0] dce_txc,
  output wire [1:0] dce_rxc,
  output wire [1:0] dce_cts,
  output wire [1:0] dce_dsr,
  output wire [1:0] dce_dcd,
  output wire [1:0] dce_ri,
  output wire [1:0] dce_tm
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bclk = 1'b0;
  logic noise = 1'b0;
  wire [1:0] loop = local_loop_request | remote_loop_request;
  // clock stands still between frames
  initial forever #62.5 bclk = run ? ~bclk : 1'b0;
  // unlooped receive line toggles so stale data never looks valid
  initial forever #8 noise = ~noise;
  assign dce_txc = {2{bclk}};
  assign dce_rxc = {2{bclk}};
  assign dce_rxd = (loop & dce_txd) | (~loop & {noise, ~noise});
  assign dce_cts = dce_rts;
  assign dce_dsr = dce_dtr;
  assign dce_dcd = loop;
  assign dce_tm = loop;
  assign dce_ri = 2'h0;
endmodule

//--- dv/tb.sv
`include "hsa_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] LOC = 2'h2;
  localparam logic [15:0] IDD = `HSA_ID_DATA;
  localparam logic [15:0] IDN = `HSA_ID_NULL;
  localparam logic [15:0] IDF = `HSA_ID_FAULT;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, adapter_fault = 1'b0;
  logic int_clk = 1'b0, int_run = 1'b0, dce_run = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, d;
  logic [1:0] board_loc = LOC;
  wire [15:0] reg_rdata;
  wire [1:0] dce_rxd, dce_cts, dce_dsr, dce_dcd, dce_txc, dce_rxc, dce_ri, dce_tm;
  wire [1:0] dce_txd, dce_rts, dce_dtr, dce_ns, local_loop_request, remote_loop_request, dce_rsel;
  wire [3:0] svc_req_ch;
  wire service_request;
  wire [4:0] svc_line;
  int miscompares = 0, tests_run = 0, cycles = 0;
  hsa_top uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .board_loc,
    .adapter_fault, .int_clk, .dce_rxd, .dce_cts, .dce_dsr, .dce_dcd, .dce_txc, .dce_rxc,
    .dce_ri, .dce_tm, .dce_txd, .dce_rts, .dce_dtr, .dce_ns, .local_loop_request,
    .remote_loop_request, .dce_rsel, .svc_req_ch, .service_request, .svc_line);
  hsa_dce_model dce (.run(dce_run), .dce_txd, .dce_rts, .dce_dtr, .local_loop_request,
    .remote_loop_request, .dce_rxd, .dce_txc, .dce_rxc, .dce_cts, .dce_dsr, .dce_dcd,
    .dce_ri, .dce_tm);
  initial forever #4 clk = ~clk;
  initial forever #62.3 int_clk = int_run ? ~int_clk : 1'b0;
  // ****************************************
  // bus and check tasks
  // ****************************************
  function automatic logic [7:0] ad(input logic [2:0] ln, input logic [2:0] ix);
    return {LOC, ln, ix};
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded so a silent channel fails instead of hanging
  task automatic wait_req(input logic [1:0] ix);
    int n;
    n = 0;
    // let a request cleared at the calling edge settle first
    step();
    while (svc_req_ch[ix] !== 1'b1 && n < 4000)
    begin
      step();
      n++;
    end
    chk({15'h0000, svc_req_ch[ix]}, 16'h0001, "request wait");
  endtask
  // two byte frame out of the transmit line, back into the receive line
  task automatic frame(input logic p, input logic [7:0] lc);
    logic [2:0] rl, tl;
    logic [15:0] v;
    rl = {1'b1, p, 1'b0};
    tl = {1'b1, p, 1'b1};
    wr(ad(tl, `HSA_IDX_LCR), {8'h00, lc});
    rd(ad(rl, `HSA_IDX_LCR), v);
    chk(v, {8'h00, lc}, "control readback");
    wait_req({p, 1'b1});
    step();
    chk({11'h000, svc_line}, {11'h000, LOC, tl}, "tx line");
    wr(ad(tl, `HSA_IDX_DATA), 16'h02A5);
    wait_req({p, 1'b1});
    wr(ad(tl, `HSA_IDX_DATA), 16'h013C);
    wait_req({p, 1'b0});
    step();
    chk({11'h000, svc_line}, {11'h000, LOC, rl}, "rx first");
    rd(ad(rl, `HSA_IDX_STAT), v);
    chk({15'h0000, v[0]}, 16'h0001, "rx ready held");
    rd(ad(rl, `HSA_IDX_DATA), v);
    chk({8'h00, v[7:0]}, 16'h00A5, "rx byte 1");
    rd(ad(rl, `HSA_IDX_STAT), v);
    chk({15'h0000, v[0]}, 16'h0000, "rx ready cleared");
    wait_req({p, 1'b0});
    rd(ad(rl, `HSA_IDX_DATA), v);
    chk({8'h00, v[7:0]}, 16'h003C, "rx byte 2");
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    step();
    chk({14'h0000, dce_txd}, 16'h0003, "txd idle");
    chk({12'h000, svc_req_ch}, 16'h0000, "no request");
    for (int i = 0; i < 8; i++)
    begin
      rd(ad(i[2:0], `HSA_IDX_ID), d);
      chk(d, {8'h00, i < 4 ? IDN[15:8] : IDD[15:8]}, "id");
    end
    adapter_fault <= 1'b1;
    repeat (4) step();
    rd(ad(3'h4, `HSA_IDX_ID), d);
    chk(d, {8'h00, IDD[15:8] | IDF[15:8]}, "fault id");
    adapter_fault <= 1'b0;
    rd({2'h1, 3'h4, `HSA_IDX_ID}, d);
    chk(d, 16'h0000, "other location");
    wr(ad(3'h1, `HSA_IDX_LCR), 16'h00FF);
    rd(ad(3'h1, `HSA_IDX_LCR), d);
    chk(d, 16'h0000, "null line");
    int_run <= 1'b1;
    frame(1'b0, 8'h0F);
    wr(ad(3'h5, `HSA_IDX_DATA), 16'h0211);
    for (int i = 0; i < 300 && d[2] !== 1'b1; i++)
      rd(ad(3'h5, `HSA_IDX_STAT), d);
    chk({15'h0000, d[2]}, 16'h0001, "underrun");
    wr(ad(3'h5, `HSA_IDX_LCR), 16'h0000);
    int_run <= 1'b0;
    repeat (3) step();
    chk({14'h0000, svc_req_ch[1:0]}, 16'h0000, "disabled");
    wr(ad(3'h7, `HSA_IDX_DCR), 16'h0003);
    repeat (3) step();
    chk({14'h0000, local_loop_request}, 16'h0002, "local loop");
    chk({14'h0000, remote_loop_request}, 16'h0002, "remote loop");
    dce_run <= 1'b1;
    frame(1'b1, 8'hF3);
    chk({8'h00, dce_ns, dce_rsel, dce_dtr, dce_rts}, 16'h00AA, "modem controls");
    dce_run <= 1'b0;
    complete_run();
  end
endmodule
